// >>> pkg/reset_cause_regs.vh
`ifndef RESET_CAUSE_REGS_VH
`define RESET_CAUSE_REGS_VH
// ==========================================================
// Register byte addresses on the AXI4-Lite slave.
`define OFF_CAUSE        8'h00
`define OFF_CONFIG       8'h04
`define OFF_EVT_STATUS   8'h08
`define OFF_EVT_MASK     8'h0C
`define OFF_TIMEOUT_STAT 8'h10
`define OFF_WAKE_CTRL    8'h14
// ==========================================================
// Field positions of the reset-cause register.
`define BIT_BROWNOUT     0
`define BIT_POWERON      1
`define BIT_PARITY_ERR   2
`define BIT_PAR_ENABLE   7
// Field positions of the configuration register.
`define CFG_OSC_RC       0
`define CFG_TIMER_SEL    1
`define CFG_BOD_ENABLE   2
`define CFG_PAR_ENABLE   3
`define CFG_RESET        4'hF
// Event bits.
`define EVT_POR          0
`define EVT_BOR          1
`define EVT_PARITY       2
`define EVT_EXT          3
`define EVT_WDT          4
`define EVT_WAKE         5
`define EVT_WIDTH        6
// ==========================================================
// Timing.
`define POWERUP_TIMER_TIME_US     72000
`define CLK_MHZ          100
`define OST_PERIODS      1024
`define IRQ_VECTOR       13'h0004
`define AXI_OKAY         2'b00
`define AXI_DECERR       2'b11
`endif

// >>> logic/parity_checker.v
`default_nettype none
// ==========================================================
// Parity check of one fetched program word.
module parity_checker #(
  parameter WIDTH = 14
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             check_enable,
  input  wire             fetch_valid,
  input  wire [WIDTH-1:0] fetch_word,
  input  wire             par_even,
  input  wire             par_odd,
  output reg              parity_fail_ff
);
  // Fold even and odd bit positions separately.
  function fold;
    input [WIDTH-1:0] w;
    input             start;
    integer           i;
    begin
      fold = 1'b0;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (i[0] == start)
          fold = fold ^ w[i];
      end
    end
  endfunction

  wire err_even;
  wire err_odd;
  assign err_even = par_even ^ fold(fetch_word, 1'b0);  // RULE_06
  assign err_odd  = ~par_odd ^ fold(fetch_word, 1'b1);  // RULE_07

  // Only a fetch while checking is on is judged, result one cycle later.
  always @(posedge aclk) begin
    if (!aresetn)
      parity_fail_ff <= 1'b0;
    else
      parity_fail_ff <= check_enable & fetch_valid & (err_even | err_odd);  // RULE_17
  end
endmodule
`default_nettype wire

// >>> logic/timeout_timer.v
`default_nettype none
// ==========================================================
// Down counter for one start-up delay phase.
module timeout_timer #(
  parameter WIDTH = 24
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             start,
  input  wire [WIDTH-1:0] length,
  output wire             busy,
  output reg              done_ff
);
  reg [WIDTH-1:0] cnt_ff;
  assign busy = (cnt_ff != {WIDTH{1'b0}});

  // A start reloads, so a restart during a run is not lost.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= {WIDTH{1'b0}};
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start)
        cnt_ff <= length;
      else if (busy) begin
        cnt_ff  <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
        done_ff <= (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/reset_cause_and_parity_check.v
`include "reset_cause_regs.vh"
`default_nettype none
// Notes on behaviour
// [RULE_01] Bit 0 brown-out flag, cleared by brown-out.
// [RULE_02] Brown-out flag meaningless when detection disabled.
// [RULE_03] Bit 1 power-on flag, cleared by power-on.
// [RULE_04] Bit 2 parity flag: parity clears, power-on sets.
// [RULE_05] Bit 7 mirrors parity enable, never reset.
// [RULE_06] Two parity bits over even/odd positions.
// [RULE_07] Even XOR, odd inverted XOR; nonzero errors.
// [RULE_08] Parity error resets and clears flag.
// [RULE_09] No failing address is recorded.
// [RULE_10] Config bit 7 one enables parity; here config register bit 3.
// [RULE_11] No-brown-out variant time-out table.
// [RULE_12] Brown-out variant time-out table.
// [RULE_13] Wake with global enable jumps to 0004h.
// [RULE_14] Base variant omits cause register, brown-out.
// [RULE_15] Power-up timer first, then oscillator timer.
// [RULE_16] Time-outs ignore external reset pin.
// [RULE_17] Check enabled fetches, reset the next cycle.
module reset_cause_and_parity_check #(
  parameter HAS_CAUSE_REG = 1,
  parameter HAS_BROWNOUT  = 1,
  parameter HAS_PARITY    = 1,
  parameter WORD_WIDTH    = 14,
  parameter CNT_WIDTH     = 24,
  parameter POWERUP_TIMER_CYCLES   = (`POWERUP_TIMER_TIME_US * `CLK_MHZ),
  parameter OST_CYCLES    = `OST_PERIODS
) (
  input  wire                  aclk,
  input  wire                  aresetn,
  input  wire                  poweron_pulse,
  input  wire                  brownout_pulse,
  input  wire                  external_reset_pin_n,
  input  wire                  watchdog_pulse,
  input  wire                  wake_pulse,
  input  wire                  global_irq_enable,
  input  wire [12:0]           next_pc,
  input  wire                  fetch_valid,
  input  wire [WORD_WIDTH-1:0] fetch_word,
  input  wire                  fetch_par_even,
  input  wire                  fetch_par_odd,
  output wire                  core_reset,
  output reg                   pc_load_ff,
  output reg  [12:0]           pc_value_ff,
  output wire                  irq,
  input  wire [7:0]            s_axi_awaddr,
  input  wire [2:0]            s_axi_awprot,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [7:0]            s_axi_araddr,
  input  wire [2:0]            s_axi_arprot,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready
);
  // ==========================================================
  // Pin synchronisers. Stage one feeds only stage two.
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 5'h1_0;
      sync2_ff <= 5'h1_0;
    end else begin
      sync1_ff <= {external_reset_pin_n, wake_pulse, watchdog_pulse, brownout_pulse, poweron_pulse};
      sync2_ff <= sync1_ff;
    end
  end
  wire por_lvl  = sync2_ff[0];
  wire bor_lvl  = sync2_ff[1] & (HAS_BROWNOUT != 0);  // RULE_14
  wire wdt_lvl  = sync2_ff[2];
  wire wake_lvl = sync2_ff[3];
  wire ext_n    = sync2_ff[4];

  // Edge detect on the synchronised levels turns them into events.
  reg [4:0] prev_ff;
  always @(posedge aclk) begin
    if (!aresetn)
      prev_ff <= 5'h1_0;
    else
      prev_ff <= {ext_n, wake_lvl, wdt_lvl, bor_lvl, por_lvl};
  end
  wire por_evt  = por_lvl & ~prev_ff[0];
  wire bor_evt  = bor_lvl & ~prev_ff[1];
  wire wdt_evt  = wdt_lvl & ~prev_ff[2];
  wire wake_evt = wake_lvl & ~prev_ff[3];
  wire ext_evt  = ~ext_n & prev_ff[4];

  // ==========================================================
  // Configuration register: stands in for the fuse word.
  reg [3:0] cfg_ff;
  wire osc_rc      = cfg_ff[`CFG_OSC_RC];
  wire timer_sel   = cfg_ff[`CFG_TIMER_SEL];
  wire bod_enable  = cfg_ff[`CFG_BOD_ENABLE] & (HAS_BROWNOUT != 0);
  wire par_enable  = cfg_ff[`CFG_PAR_ENABLE] & (HAS_PARITY != 0);  // RULE_10

  // ==========================================================
  // Parity check of fetched words.
  wire parity_fail;
  parity_checker #(
    .WIDTH (WORD_WIDTH)
  ) u_parity (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .check_enable   (par_enable),
    .fetch_valid    (fetch_valid),
    .fetch_word     (fetch_word),
    .par_even       (fetch_par_even),
    .par_odd        (fetch_par_odd),
    .parity_fail_ff (parity_fail)
  );
  wire bor_reset = bor_evt & bod_enable;

  // ==========================================================
  // Start-up sequencer. One-hot states.
  localparam ST_RUN  = 4'b0001;
  localparam ST_POWERUP_TIMER = 4'b0010;
  localparam ST_OST  = 4'b0100;
  localparam ST_HOLD = 4'b1000;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg       tmr_start;
  reg [CNT_WIDTH-1:0] tmr_len;
  wire tmr_busy;
  wire tmr_done;
  timeout_timer #(
    .WIDTH (CNT_WIDTH)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (tmr_start),
    .length  (tmr_len),
    .busy    (tmr_busy),
    .done_ff (tmr_done)
  );
  wire powerup_timer_on = (HAS_BROWNOUT != 0) ? ~timer_sel : timer_sel;  // RULE_11 RULE_12
  localparam [CNT_WIDTH-1:0] POWERUP_TIMER_LEN = POWERUP_TIMER_CYCLES[CNT_WIDTH-1:0];
  localparam [CNT_WIDTH-1:0] OST_LEN  = OST_CYCLES[CNT_WIDTH-1:0];

  // Power-on and brown-out restart the timers from any state, so the first
  // power-on after a bus reset leaves the idle power-up state; wake runs only
  // the oscillator timer.
  always @* begin
    nxt_state = state_ff;
    tmr_start = 1'b0;
    tmr_len   = POWERUP_TIMER_LEN;
    case (state_ff)
      ST_RUN: begin
        if (wake_evt && !osc_rc) begin  // RULE_11 RULE_12
          nxt_state = ST_OST;
          tmr_start = 1'b1;
          tmr_len   = OST_LEN;
        end else if (parity_fail || wdt_evt || ext_evt) begin  // RULE_08
          nxt_state = ST_HOLD;
        end
      end
      ST_POWERUP_TIMER: begin
        if (tmr_done) begin
          if (osc_rc) begin
            nxt_state = ST_HOLD;
          end else begin
            nxt_state = ST_OST;  // RULE_15
            tmr_start = 1'b1;
            tmr_len   = OST_LEN;
          end
        end
      end
      ST_OST: begin
        if (tmr_done)
          nxt_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (ext_n)
          nxt_state = ST_RUN;  // RULE_16
      end
      default: nxt_state = ST_HOLD;
    endcase
    if (por_evt || bor_reset) begin
      tmr_start = 1'b1;
      if (powerup_timer_on || osc_rc || bor_reset) begin  // RULE_12
        nxt_state = ST_POWERUP_TIMER;
        tmr_len   = POWERUP_TIMER_LEN;
      end else begin
        nxt_state = ST_OST;
        tmr_len   = OST_LEN;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn)
      state_ff <= ST_POWERUP_TIMER;
    else
      state_ff <= nxt_state;
  end
  // Timers run regardless of the pin; only the hold waits on it.
  assign core_reset = ~state_ff[0] | ~ext_n;  // RULE_16

  // Wake with interrupts enabled vectors; otherwise fall through.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pc_load_ff  <= 1'b0;
      pc_value_ff <= 13'h0_000;
    end else begin
      pc_load_ff  <= wake_evt;
      pc_value_ff <= global_irq_enable ? `IRQ_VECTOR : next_pc;  // RULE_13
    end
  end

  // ==========================================================
  // AXI4-Lite slave. Address and data taken in either order.
  reg        aw_ok_ff;
  reg [7:0]  aw_addr_ff;
  reg        w_ok_ff;
  reg [31:0] w_data_ff;
  reg [3:0]  w_strb_ff;
  assign s_axi_awready = ~aw_ok_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_ok_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire   wr_go = aw_ok_ff & w_ok_ff;
  wire   wr_low = wr_go & w_strb_ff[0];

  reg [7:0] cause_ff;
  reg [`EVT_WIDTH-1:0] evt_ff;
  reg [`EVT_WIDTH-1:0] mask_ff;
  wire [`EVT_WIDTH-1:0] evt_new = {wake_evt, wdt_evt, ext_evt, parity_fail, bor_reset, por_evt};
  wire [7:0] cause_view = (HAS_CAUSE_REG != 0) ?
    {par_enable, 4'h0, (HAS_PARITY != 0) & cause_ff[2], cause_ff[1], (HAS_BROWNOUT != 0) & cause_ff[0]} :
    8'h0_0;  // RULE_05 RULE_14

  // Register map decode.
  function [31:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `OFF_CAUSE:        reg_read = {24'h00_0000, cause_view};
        `OFF_CONFIG:       reg_read = {28'h000_0000, cfg_ff};
        `OFF_EVT_STATUS:   reg_read = {26'h000_0000, evt_ff};
        `OFF_EVT_MASK:     reg_read = {26'h000_0000, mask_ff};
        `OFF_TIMEOUT_STAT: reg_read = {28'h000_0000, state_ff};
        default:           reg_read = 32'h0000_0000;
      endcase
    end
  endfunction
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OFF_CAUSE) || (a == `OFF_CONFIG) || (a == `OFF_EVT_STATUS) ||
               (a == `OFF_EVT_MASK) || (a == `OFF_TIMEOUT_STAT);
    end
  endfunction

  // Write channel bookkeeping and response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff     <= 1'b0;
      w_ok_ff      <= 1'b0;
      aw_addr_ff   <= 8'h0_0;
      w_data_ff    <= 32'h0000_0000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff   <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff   <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_ff     <= 1'b0;
        w_ok_ff      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_ff) ? `AXI_OKAY : `AXI_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= reg_read(s_axi_araddr);
      s_axi_rresp  <= mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Cause flags. Hardware clears win over a software set.
  // The brown-out bit is left as written when detection is off.
  // Nothing stores the failing fetch address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cause_ff <= 8'h0_6;
      cfg_ff   <= `CFG_RESET;
    end else begin
      if (wr_low && aw_addr_ff == `OFF_CAUSE)
        cause_ff[2:0] <= cause_ff[2:0] | w_data_ff[2:0];
      if (wr_low && aw_addr_ff == `OFF_CONFIG)
        cfg_ff <= w_data_ff[3:0];
      if (bor_reset)
        cause_ff[`BIT_BROWNOUT] <= 1'b0;  // RULE_01 RULE_02
      if (por_evt) begin
        cause_ff[`BIT_POWERON]    <= 1'b0;  // RULE_03
        cause_ff[`BIT_PARITY_ERR] <= 1'b1;  // RULE_04
      end
      if (parity_fail)
        cause_ff[`BIT_PARITY_ERR] <= 1'b0;  // RULE_08 RULE_09
    end
  end

  // ==========================================================
  // Event status, write one to clear; a new event wins.
  always @(posedge aclk) begin
    if (!aresetn) begin
      evt_ff  <= {`EVT_WIDTH{1'b0}};
      mask_ff <= {`EVT_WIDTH{1'b0}};
    end else begin
      if (wr_low && aw_addr_ff == `OFF_EVT_MASK)
        mask_ff <= w_data_ff[`EVT_WIDTH-1:0];
      if (wr_low && aw_addr_ff == `OFF_EVT_STATUS)
        evt_ff <= (evt_ff & ~w_data_ff[`EVT_WIDTH-1:0]) | evt_new;
      else
        evt_ff <= evt_ff | evt_new;
    end
  end
  assign irq = |(evt_ff & mask_ff);

endmodule
`default_nettype wire

// >>> bench/reset_cause_and_parity_check_assertions.sv
`include "reset_cause_regs.vh"
`default_nettype none
// ==========
// Port-level checks of the reset-cause and parity block.
module reset_cause_and_parity_check_assertions #(
  parameter int WORD_WIDTH = 14
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  external_reset_pin_n,
  input wire logic                  global_irq_enable,
  input wire logic                  fetch_valid,
  input wire logic [WORD_WIDTH-1:0] fetch_word,
  input wire logic                  fetch_par_even,
  input wire logic                  fetch_par_odd,
  input wire logic                  core_reset,
  input wire logic                  pc_load_ff,
  input wire logic [12:0]           pc_value_ff,
  input wire logic                  irq,
  input wire logic [7:0]            s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [WORD_WIDTH-1:0] EVEN_M = WORD_WIDTH'({WORD_WIDTH{2'b01}});
  logic par_en_ff;
  logic par_bad;
  // Shadow of the parity enable; the checker cannot read registers, so it follows config writes whose address and data are taken in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par_en_ff <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `OFF_CONFIG) begin
      par_en_ff <= s_axi_wdata[`CFG_PAR_ENABLE];
    end
  end
  // Even half uses even parity, odd half odd parity.
  assign par_bad = (^(fetch_word & EVEN_M) ^ fetch_par_even) | (^(fetch_word & ~EVEN_M) ^ ~fetch_par_odd);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // Properties.
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response repeated");
  property p_after_rst;
    $rose(aresetn) |-> core_reset && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_after_rst: assert property (p_after_rst) else $error("bad state after reset");
  property p_par;
    !core_reset && fetch_valid && par_en_ff && par_bad |-> ##[1:3] core_reset;
  endproperty
  a_par: assert property (p_par) else $error("parity fault gave no core reset");
  property p_pin;
    !external_reset_pin_n |-> ##[0:4] core_reset;
  endproperty
  a_pin: assert property (p_pin) else $error("pin low without core reset");
  property p_wake;
    pc_load_ff && $past(global_irq_enable) |-> pc_value_ff == `IRQ_VECTOR;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not vector");
endmodule

bind reset_cause_and_parity_check reset_cause_and_parity_check_assertions #(.WORD_WIDTH(WORD_WIDTH)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .external_reset_pin_n(external_reset_pin_n),
  .global_irq_enable(global_irq_enable), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
  .fetch_par_even(fetch_par_even), .fetch_par_odd(fetch_par_odd), .core_reset(core_reset),
  .pc_load_ff(pc_load_ff), .pc_value_ff(pc_value_ff), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// >>> bench/reset_cause_and_parity_check_bench.sv
`include "reset_cause_regs.vh"
`default_nettype none
// ==========
// Self-checking bench driving the register bus, events and fetches.
module reset_cause_and_parity_check_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, external_reset_pin_n, global_irq_enable, fetch_valid, fetch_par_even;
  logic        fetch_par_odd, core_reset, pc_load_ff, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  pulses;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [12:0] next_pc, pc_value_ff;
  logic [13:0] fetch_word;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  int          err_count = 0;
  int          checked = 0;

  // Shortened start-up delays keep the run brief.
  reset_cause_and_parity_check #(.POWERUP_TIMER_CYCLES(50), .OST_CYCLES(8)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .poweron_pulse(pulses[0]), .brownout_pulse(pulses[1]),
    .watchdog_pulse(pulses[2]), .wake_pulse(pulses[3]), .external_reset_pin_n(external_reset_pin_n),
    .global_irq_enable(global_irq_enable), .next_pc(next_pc), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_par_even(fetch_par_even), .fetch_par_odd(fetch_par_odd),
    .core_reset(core_reset), .pc_load_ff(pc_load_ff), .pc_value_ff(pc_value_ff), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  // ==========
  // Clock and hang guard.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #100us;
    err_count++;
    results();
  end

  // ==========
  // Helpers.
  task automatic results();
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // Of the offsets used here, only the spare one is unmapped.
  function automatic logic [31:0] resp_of(input logic [7:0] a);
    return (a == `OFF_WAKE_CTRL) ? 32'(`AXI_DECERR) : 32'(`AXI_OKAY);
  endfunction
  // Handshakes are judged on the values that stand at the rising edge; each valid drops once taken.
  // Ready for the answer comes late on purpose so that the response has to stand.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        chk("bresp", resp_of(a), 32'(s_axi_bresp));
        return;
      end
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        rd_data = s_axi_rdata;
        chk("rresp", resp_of(a), 32'(s_axi_rresp));
        chk("rdata", e, rd_data & m);
        return;
      end
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
  endtask
  task automatic run_wait(input int n);
    repeat (n) begin
      @(negedge aclk);
      if (core_reset === 1'b0) return;
    end
    chk("core_reset", 32'h0000_0000, 32'h0000_0001);
  endtask
  // Event inputs are slow levels; a few cycles get them through the synchronisers.
  // A watchdog reset holds the core for one cycle only, so the whole window is watched.
  task automatic kick(input int k);
    logic seen;
    seen = 1'b0;
    @(posedge aclk);
    pulses[k] <= 1'b1;
    repeat (6) begin
      @(negedge aclk);
      seen = seen | core_reset;
    end
    @(posedge aclk);
    pulses[k] <= 1'b0;
    chk("core_reset", 32'h0000_0001, 32'(seen));
  endtask
  task automatic irq_is(input logic e);
    @(negedge aclk);
    chk("irq", 32'(e), 32'(irq));
  endtask
  // Bit b[0] spoils the even check bit, b[1] the odd one.
  task automatic fetch(input logic [13:0] w, input logic [1:0] b, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge aclk);
    fetch_word <= w;
    fetch_par_even <= ^(w & 14'h1555) ^ b[0];
    fetch_par_odd <= ~^(w & 14'h2AAA) ^ b[1];
    fetch_valid <= 1'b1;
    @(posedge aclk);
    fetch_valid <= 1'b0;
    repeat (4) begin
      @(negedge aclk);
      seen = seen | core_reset;
    end
    chk("parity_reset", 32'(e), 32'(seen));
    run_wait(20);
  endtask
  task automatic wake(input logic g, input logic [12:0] e);
    logic [12:0] got;
    got = 13'bx;
    @(posedge aclk);
    global_irq_enable <= g;
    pulses[3] <= 1'b1;
    repeat (8) begin
      @(negedge aclk);
      if (pc_load_ff === 1'b1) got = pc_value_ff;
    end
    @(posedge aclk);
    pulses[3] <= 1'b0;
    chk("pc_value", 32'(e), 32'(got));
  endtask

  // ==========
  // Test sequence.
  initial begin
    {aresetn, pulses, global_irq_enable, fetch_valid, fetch_par_even, fetch_par_odd} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fetch_word} = '0;
    external_reset_pin_n = 1'b1;
    next_pc = 13'h0123;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`OFF_CONFIG, 32'hFFFF_FFFF, 32'h0000_000F);
    rc(`OFF_WAKE_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(`OFF_WAKE_CTRL, 32'h0000_0001);
    kick(0);
    run_wait(200);
    rc(`OFF_CAUSE, 32'h0000_0086, 32'h0000_0084);
    wr(`OFF_CAUSE, 32'h0000_0007);
    rc(`OFF_CAUSE, 32'h0000_00FF, 32'h0000_0087);
    rc(`OFF_EVT_STATUS, 32'h0000_0001, 32'h0000_0001);
    irq_is(1'b0);
    wr(`OFF_EVT_MASK, 32'h0000_0001);
    irq_is(1'b1);
    wr(`OFF_EVT_STATUS, 32'h0000_0001);
    irq_is(1'b0);
    kick(1);
    run_wait(200);
    rc(`OFF_CAUSE, 32'h0000_0087, 32'h0000_0086);
    // Clean word, then each check bit spoiled in turn.
    for (int i = 0; i < 3; i++) begin
      fetch(14'h2D4B, i[1:0], i != 0);
      rc(`OFF_CAUSE, 32'h0000_0086, (i == 0) ? 32'h0000_0086 : 32'h0000_0082);
      wr(`OFF_CAUSE, 32'h0000_0004);
    end
    wr(`OFF_CONFIG, 32'h0000_0007);
    rc(`OFF_CAUSE, 32'h0000_0080, 32'h0000_0000);
    fetch(14'h0F0F, 2'h1, 1'b0);
    wr(`OFF_CONFIG, 32'h0000_000F);
    wake(1'b1, `IRQ_VECTOR);
    wake(1'b0, 13'h0123);
    kick(2);
    run_wait(50);
    // Pin held low across the whole power-up delay, then released.
    @(posedge aclk);
    external_reset_pin_n <= 1'b0;
    kick(0);
    repeat (120) @(posedge aclk);
    external_reset_pin_n <= 1'b1;
    run_wait(8);
    results();
  end
endmodule
`default_nettype wire
